/* logic/standby_mode_control.sv */
`timescale 1ns/1ps
module standby_mode_control #(
  parameter logic [19:0] WAIT_STATES_1010 = 20'h04000,
  parameter logic [19:0] WAIT_STATES_1011 = 20'h08000,
  parameter logic [19:0] WAIT_STATES_1100 = 20'h10000,
  parameter logic [19:0] WAIT_STATES_1101 = 20'h20000,
  parameter logic [19:0] WAIT_STATES_1110 = 20'h40000,
  parameter logic [19:0] WAIT_STATES_1111 = 20'h80000
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SLEEP_EXEC,
  input wire logic IRQ_PEND,
  input wire logic EXT_WAKE,
  output standby_pkg::pwr_ctl_s PWR_CTL,
  output standby_pkg::pmode_e MODE
);
  import standby_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [7:0] ctrl;
    pmode_e mode;
    logic [31:0] rdata;
    logic wake_meta;
    logic wake_sync;
    pwr_ctl_s pwr;
  } top_state_s;

  top_state_s st_reg;
  top_state_s st_next;
  // handshake and decode nets, all on MCLK
  logic wait_load;
  logic wait_busy;
  logic wait_done;
  logic [WAIT_CNT_W-1:0] wait_states;
  logic apb_setup;
  logic apb_write;
  logic addr_ok;

  // ************************************************************
  // wake wait decode
  // ************************************************************
  // prohibited low codes fall back to the longest wait so a bad setting
  // errs on the side of a settled clock rather than a glitching one
  always_comb begin
    case (st_reg.ctrl[WAKE_WAIT_SEL_LSB +: WAKE_WAIT_SEL_W])
      4'h5: wait_states = WAIT_STATES_0101;
      4'h6: wait_states = WAIT_STATES_0110;
      4'h7: wait_states = WAIT_STATES_0111;
      4'h8: wait_states = WAIT_STATES_1000;
      4'h9: wait_states = WAIT_STATES_1001;
      4'ha: wait_states = WAIT_STATES_1010;
      4'hb: wait_states = WAIT_STATES_1011;
      4'hc: wait_states = WAIT_STATES_1100;
      4'hd: wait_states = WAIT_STATES_1101;
      4'he: wait_states = WAIT_STATES_1110;
      4'hf: wait_states = WAIT_STATES_1111;
      default: wait_states = WAIT_STATES_1111; // guards codes the software must avoid
    endcase
  end

  // ************************************************************
  // apb decode
  // ************************************************************
  // zero wait state slave: every access completes in its first access cycle
  always_comb begin
    apb_setup = PSEL && !PENABLE;
    apb_write = PSEL && PENABLE && PWRITE;
    if (PADDR == STANDBY_CONTROL_OFFSET) begin
      addr_ok = 1'b1;
    end else if (PADDR == STANDBY_STATUS_OFFSET) begin
      addr_ok = 1'b1;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // ************************************************************
  // next state
  // ************************************************************
  // one pass works out the next register set from the bus, the wake pin and the mode
  always_comb begin
    st_next = st_reg;
    wait_load = 1'b0;
    // external wake pin through two flops before anything reads it
    st_next.wake_meta = EXT_WAKE;
    st_next.wake_sync = st_reg.wake_meta;

    // register writes; reserved bits are masked to zero
    if (apb_write && PADDR == STANDBY_CONTROL_OFFSET) begin
      st_next.ctrl = PWDATA[7:0] & STANDBY_CONTROL_WMASK;
    end

    // read data captured in the setup cycle so it leaves a flop
    // status is read only: a write to it is dropped without an error
    if (apb_setup) begin
      if (PADDR == STANDBY_CONTROL_OFFSET) begin
        st_next.rdata = {24'h000000, st_reg.ctrl & STANDBY_CONTROL_WMASK};
      end else if (PADDR == STANDBY_STATUS_OFFSET) begin
        st_next.rdata = {29'h00000000, wait_busy, st_reg.mode};
      end else begin
        st_next.rdata = 32'h00000000;
      end
    end

    // power mode sequencing
    case (st_reg.mode)
      MODE_RUN: begin
        // the halt instruction arrives as a one-cycle pulse; the select bit picks the target
        if (SLEEP_EXEC) begin
          if (st_reg.ctrl[SLEEP_TARGET_SELECT_BIT]) begin
            st_next.mode = MODE_STANDBY;
          end else begin
            st_next.mode = MODE_SLEEP;
          end
        end
      end
      MODE_SLEEP: begin
        // the oscillator never stopped, so sleep ends with no settle wait
        if (IRQ_PEND) begin
          st_next.mode = MODE_RUN;
        end
      end
      MODE_STANDBY: begin
        // the select bit is deliberately left alone on wake
        if (st_reg.wake_sync) begin
          st_next.mode = MODE_WAKE_WAIT;
          wait_load = 1'b1;
        end
      end
      MODE_WAKE_WAIT: begin
        if (wait_done) begin
          st_next.mode = MODE_RUN;
        end
      end
      default: begin
        st_next.mode = MODE_RUN;
      end
    endcase

    // outputs registered from the next mode
    st_next.pwr.cpu_halt = (st_next.mode != MODE_RUN);
    st_next.pwr.periph_halt = (st_next.mode == MODE_STANDBY) ||
                              (st_next.mode == MODE_WAKE_WAIT);
    st_next.pwr.osc_stop = (st_next.mode == MODE_STANDBY);
    // float only in standby with the hold bit clear
    st_next.pwr.bus_oe = !((st_next.mode == MODE_STANDBY) &&
                           !st_next.ctrl[STANDBY_OUTPUT_HOLD_BIT]);
    // freeze the last levels in standby with the hold bit set
    st_next.pwr.bus_hold = (st_next.mode == MODE_STANDBY) &&
                           st_next.ctrl[STANDBY_OUTPUT_HOLD_BIT];
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      st_reg.ctrl <= STANDBY_CONTROL_RESET;
      st_reg.mode <= MODE_RUN;
      st_reg.rdata <= 32'h00000000;
      st_reg.wake_meta <= 1'b0;
      st_reg.wake_sync <= 1'b0;
      st_reg.pwr <= '{cpu_halt: 1'b0, periph_halt: 1'b0, osc_stop: 1'b0, bus_oe: 1'b1, bus_hold: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ************************************************************
  // settle counter
  // ************************************************************
  // the oscillator restarts on wake, so counting MCLK states is the settle time
  // the mode steps to run one edge after done, so the cpu is held for the count plus one
  wake_wait_counter #(
    .CNT_W(WAIT_CNT_W)
  ) u_wake_wait (
    .clk(MCLK),
    .rst(RST),
    .load(wait_load),
    .load_val(wait_states),
    .busy(wait_busy),
    .done(wait_done)
  );

  // ************************************************************
  // outputs
  // ************************************************************
  // read data leaves a flop; the slave never stretches a transfer, so ready is constant
  assign PRDATA = st_reg.rdata;
  assign PREADY = 1'b1;

  // unmapped addresses flag an error and change nothing
  assign PSLVERR = PSEL && PENABLE && !addr_ok;

  // power controls and mode come straight from flops, so the pads see no glitches
  assign PWR_CTL = st_reg.pwr;
  assign MODE = st_reg.mode;

endmodule

/* logic/standby_pkg.sv */
package standby_pkg;

  // ************************************************************
  // register map and field layout
  // ************************************************************
  localparam logic [7:0] STANDBY_CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] STANDBY_STATUS_OFFSET = 8'h04;
  localparam int SLEEP_TARGET_SELECT_BIT = 7;
  localparam int STANDBY_OUTPUT_HOLD_BIT = 6;
  localparam int WAKE_WAIT_SEL_LSB = 0;
  localparam int WAKE_WAIT_SEL_W = 4;
  localparam logic [7:0] STANDBY_CONTROL_RESET = 8'h4f;
  localparam logic [7:0] STANDBY_CONTROL_WMASK = 8'hcf;

  // ************************************************************
  // wake wait counts, in clock states
  // ************************************************************
  localparam int WAIT_CNT_W = 20;
  localparam logic [WAIT_CNT_W-1:0] WAIT_STATES_0101 = 20'h00040;
  localparam logic [WAIT_CNT_W-1:0] WAIT_STATES_0110 = 20'h00200;
  localparam logic [WAIT_CNT_W-1:0] WAIT_STATES_0111 = 20'h00400;
  localparam logic [WAIT_CNT_W-1:0] WAIT_STATES_1000 = 20'h00800;
  localparam logic [WAIT_CNT_W-1:0] WAIT_STATES_1001 = 20'h01000;
  localparam logic [3:0] WAIT_CODE_LOW_MAX = 4'h4;

  // ************************************************************
  // modes and carriers
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_STANDBY,
    MODE_WAKE_WAIT
  } pmode_e;

  typedef struct packed {
    logic cpu_halt;
    logic periph_halt;
    logic osc_stop;
    logic bus_oe;
    logic bus_hold;
  } pwr_ctl_s;

endpackage

/* logic/wake_wait_counter.sv */
`timescale 1ns/1ps
module wake_wait_counter #(
  parameter int CNT_W = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [CNT_W-1:0] load_val,
  output logic busy,
  output logic done
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic busy;
    logic done;
  } cnt_state_s;

  cnt_state_s st_reg;
  cnt_state_s st_next;

  // count down one per clock state; done pulses once when the count runs out
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (load) begin
      st_next.cnt = load_val - CNT_W'(1);
      st_next.busy = 1'b1;
    end else if (st_reg.busy) begin
      if (st_reg.cnt == '0) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt - CNT_W'(1);
      end
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy = st_reg.busy;
  assign done = st_reg.done;

endmodule

/* test/standby_mode_control_properties.sv */
`timescale 1ns/1ps
module standby_mode_control_properties (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic SLEEP_EXEC,
  input wire logic IRQ_PEND,
  input wire logic EXT_WAKE,
  input wire standby_pkg::pwr_ctl_s PWR_CTL,
  input wire standby_pkg::pmode_e MODE
);
  import standby_pkg::*;
  logic [1:0] shadow_reg;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // ************************************************************
  // shadow of select and hold bits
  // ************************************************************
  // tracked from bus writes, since the register itself is not a port
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) shadow_reg <= 2'b01;
    else if (PSEL && PENABLE && PWRITE && PADDR == STANDBY_CONTROL_OFFSET) shadow_reg <= PWDATA[7:6];
  end
  // ************************************************************
  // properties
  // ************************************************************
  a_sleep_entry: assert property (MODE == MODE_RUN && SLEEP_EXEC && !shadow_reg[1] |=> MODE == MODE_SLEEP)
    else $error("halt did not enter sleep");
  a_standby_entry: assert property (MODE == MODE_RUN && SLEEP_EXEC && shadow_reg[1] |=> MODE == MODE_STANDBY)
    else $error("halt did not enter standby");
  a_bus_float: assert property (MODE == MODE_STANDBY && !shadow_reg[0] && $stable(shadow_reg) |-> !PWR_CTL.bus_oe)
    else $error("bus driven in standby with hold off");
  a_bus_hold: assert property (MODE == MODE_STANDBY && shadow_reg[0] && $stable(shadow_reg) |-> PWR_CTL.bus_oe && PWR_CTL.bus_hold)
    else $error("bus not held in standby");
  a_standby_halts: assert property (MODE == MODE_STANDBY |-> PWR_CTL.cpu_halt && PWR_CTL.periph_halt && PWR_CTL.osc_stop)
    else $error("standby left something running");
  a_reserved_zero: assert property (PSEL && PENABLE && !PWRITE && PADDR == STANDBY_CONTROL_OFFSET |-> PRDATA[5:4] == 2'b00)
    else $error("reserved bits read nonzero");
  a_wake_held: assert property (MODE == MODE_WAKE_WAIT |-> PWR_CTL.cpu_halt && !PWR_CTL.osc_stop)
    else $error("cpu not held during settle wait");
  a_wake_start: assert property (MODE == MODE_STANDBY && $rose(EXT_WAKE) |-> ##[1:4] MODE == MODE_WAKE_WAIT)
    else $error("wake did not start settle wait");
  a_sleep_exit: assert property (MODE == MODE_SLEEP && IRQ_PEND |=> MODE == MODE_RUN)
    else $error("interrupt did not end sleep");
endmodule
bind standby_mode_control standby_mode_control_properties chk (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .SLEEP_EXEC(SLEEP_EXEC), .IRQ_PEND(IRQ_PEND),
  .EXT_WAKE(EXT_WAKE), .PWR_CTL(PWR_CTL), .MODE(MODE));

/* test/standby_mode_control_bench.sv */
`timescale 1ns/1ps
module standby_mode_control_bench;
  import standby_pkg::*;
  logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, sleep_exec = 0, irq_pend = 0, ext_wake = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic pready, pslverr, err;
  pwr_ctl_s pwr_ctl;
  pmode_e mode;
  int miscompares = 0, total_checks = 0, cycles = 0;
  standby_mode_control #(.WAIT_STATES_1010(20'h00010), .WAIT_STATES_1111(20'h00060)) dut (.MCLK(mclk), .RST(rst),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SLEEP_EXEC(sleep_exec), .IRQ_PEND(irq_pend), .EXT_WAKE(ext_wake),
    .PWR_CTL(pwr_ctl), .MODE(mode));
  // ************************************************************
  // clock, timeout and shared tasks
  // ************************************************************
  always #25 mclk = ~mclk;
  // a hung wait would otherwise never reach the verdict
  always @(posedge mclk) begin
    cycles++;
    if (cycles > 5000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    // this wait ends at the first edge that sees pready high; the bench timeout ends a hung one
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // outputs read at an edge are the settled values of the cycle before it
  task automatic step(int n);
    repeat (n) @(posedge mclk);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_registers();
    apb(0, 8'h00, 0);
    check("reset control", q, 32'h0000004f);
    apb(1, 8'h00, 32'hffffffcf); // reserved bits written as zero
    apb(0, 8'h00, 0);
    check("reserved bits", q, 32'h000000cf);
    apb(0, 8'h08, 0);
    check("unmapped data", q, 32'h00000000);
    check("unmapped error", {31'h0, err}, 32'h00000001);
  endtask
  task automatic t_sleep();
    apb(1, 8'h00, 32'h0000004f);
    sleep_exec <= 1;
    step(1);
    sleep_exec <= 0;
    step(2);
    check("sleep mode", mode, MODE_SLEEP);
    check("sleep ctl", pwr_ctl, 5'b10010);
    apb(0, 8'h04, 0);
    check("sleep status", q, 32'h00000001);
    check("status error", {31'h0, err}, 32'h00000000);
    irq_pend <= 1;
    step(2);
    irq_pend <= 0;
    check("sleep exit", mode, MODE_RUN);
  endtask
  // enter standby, wake, and time the settle wait
  task automatic t_standby(logic [7:0] val, int states);
    int n;
    apb(1, 8'h00, {24'h0, val});
    sleep_exec <= 1;
    step(1);
    sleep_exec <= 0;
    step(2);
    check("standby mode", mode, MODE_STANDBY);
    check("standby ctl", pwr_ctl, {3'b111, val[6], val[6]});
    ext_wake <= 1;
    n = 0;
    while (mode !== MODE_WAKE_WAIT && n < 10) begin
      step(1);
      n++;
    end
    check("wake latency", n, 4);
    ext_wake <= 0;
    n = 0;
    while (mode === MODE_WAKE_WAIT && n < 200) begin
      step(1);
      n++;
    end
    check("settle states", n, states + 1);
    check("resumed ctl", pwr_ctl, 5'b00010);
    apb(0, 8'h00, 0);
    check("select kept", q, {24'h0, val[7:6], 2'b00, val[3:0]});
    apb(1, 8'h00, {24'h0, 1'b0, val[6:0]});
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    step(8);
    rst <= 0;
    t_registers();
    t_sleep();
    t_standby(8'h85, 64); // only permitted wait codes are programmed
    t_standby(8'hca, 16);
    t_standby(8'hcf, 96);
    complete_run();
  end
endmodule
